// file: shared/hbp_pkg.sv
// Constants, register map and state types of the half-bridge PWM block.
// Assumes a 32-bit classic Wishbone master and one 250 MHz PWM clock.
//
// Functional notes
// - 12-bit counter, period plus one, duty output
// - Complement is inverse of main waveform
// - Separate duty and period match flags
// - Period, duty, dead times reload at zero
// - Output A rise delayed dead_time_a+1
// - Output B rise delayed dead_time_b+1
// - Each detector compares output with current
// - Phase high while current lags voltage
// - Voltage lagging gives no width, protects
// - Protect flag when width below window+1
// - Short flag nonzero below window+1, zero flag zero
// - Enabled source high sets shutdown flag
// - No step-down: turn off at period end
// - Step period down once per period
// - Abort without command: stop, keep run/done
// - Abort or finish with command: full turn-off
// - 10-bit tick counter, selectable clock source
// - Timer mode counts to 1023, overflow flag
// - Sample time elapsed: capture, flag, stop
// - Sample time is clock over 8192<<code
// - counter_on rise clears counter and capture
// - Shared low-byte buffer for byte pairs
package hbp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HBP_OFS_CTRL      = 8'h00;
  localparam logic [7:0] HBP_OFS_STAT      = 8'h04;
  localparam logic [7:0] HBP_OFS_SDEN      = 8'h08;
  localparam logic [7:0] HBP_OFS_PAIR      = 8'h10;
  localparam logic [7:0] HBP_PAIR_STRIDE   = 8'h08;
  localparam logic [7:0] HBP_PAIR_HI       = 8'h04;
  localparam logic [7:0] HBP_OFS_STEP      = 8'h50;
  localparam logic [7:0] HBP_OFS_WIN       = 8'h54;
  localparam logic [7:0] HBP_OFS_TMC0      = 8'h58;
  localparam logic [7:0] HBP_OFS_TMC1      = 8'h5C;

  // Pair indices: 0..4 writable, 5..7 read only
  localparam int HBP_P_PER  = 0;
  localparam int HBP_P_DUTY = 1;
  localparam int HBP_P_DTA  = 2;
  localparam int HBP_P_MIN  = 4;
  localparam int HBP_NPAIR_W = 5;
  localparam int HBP_NPAIR   = 8;

  // Status flag positions
  localparam int HBP_F_DUTY = 0;
  localparam int HBP_F_PER  = 1;
  localparam int HBP_F_PP   = 2;
  localparam int HBP_F_SP   = 3;
  localparam int HBP_F_ZP   = 4;
  localparam int HBP_F_SD   = 5;
  localparam int HBP_F_OD   = 6;
  localparam int HBP_F_OVF  = 7;
  localparam int HBP_F_CAP  = 8;

  // Timing: sample divider base and tick counter top
  localparam int          HBP_SAMPLE_DIV = 8192;
  localparam logic [9:0]  HBP_TICK_MAX   = 10'h3FF;
  localparam logic [8:0]  HBP_PW_MAX     = 9'h1FF;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } hbp_wb_req_t;

  typedef struct packed {
    logic                            ack;
    logic [31:0]                     rdat;
    logic [7:0]                      lowbuf;
    logic                            run;
    logic                            dead_time_enable;
    logic                            sde;
    logic                            abort;
    logic                            turnoff;
    logic [1:0]                      msel;
    logic [1:0]                      mdat;
    logic [8:0]                      flag;
    logic [3:0]                      sden;
    logic [HBP_NPAIR_W-1:0][11:0]    pair;
    logic [11:0]                     per_act;
    logic [11:0]                     duty_act;
    logic [1:0][11:0]                dt_act;
    logic [7:0]                      step;
    logic [7:0]                      win;
    logic [11:0]                     cnt;
    logic [1:0][11:0]                dcnt;
    logic [1:0]                      pout;
    logic [1:0]                      pprev;
    logic [1:0][8:0]                 pw;
    logic [1:0]                      zs1;
    logic [1:0]                      zs2;
    logic [2:0]                      os1;
    logic [2:0]                      os2;
    logic [2:0]                      es;
    logic [2:0]                      ls;
    logic                            step_end;
    logic                            stop_req;
    logic                            stop_full;
    logic                            tcon;
    logic [2:0]                      tcks;
    logic [2:0]                      stsel;
    logic [1:0]                      tmode;
    logic [9:0]                      tcnt;
    logic [9:0]                      tcap;
    logic [5:0]                      presc;
    logic [19:0]                     samp;
  } hbp_state_t;

  localparam hbp_state_t HBP_STATE_RST = '0;

endpackage

// file: core/hbp_top.sv
// Half-bridge complementary PWM with dead time, phase protection,
// automatic turn-off with period step-down, and a 10-bit tick counter.
// Assumes all inputs except the Wishbone bus, clock and reset are asynchronous pins.
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
module hbp_top
  import hbp_pkg::*;
#(
  parameter int SAMPLE_BASE_CYC = HBP_SAMPLE_DIV
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire hbp_wb_req_t wb_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // Comparator inputs
  input  wire logic        zero_current_a_i,
  input  wire logic        zero_current_b_i,
  input  wire logic        overvolt_src_c_i,
  input  wire logic        overvolt_src_d_i,
  input  wire logic        overvolt_src_e_i,
  // Tick counter clock sources
  input  wire logic        event_clock_signal_i,
  input  wire logic        low_clk_i,
  // Gate drive and phase outputs
  output logic             output_a_o,
  output logic             output_b_o,
  output logic [1:0]       phase_o
);

  hbp_state_t                 s_q;
  hbp_state_t                 s_d;
  logic                       req;
  logic                       wr;
  logic                       wrap;
  logic                       main_w;
  logic [1:0]                 raw;
  logic [1:0]                 ph;
  logic [1:0]                 ev;
  logic [8:0]                 thr;
  logic [12:0]                diff;
  logic                       stepping;
  logic                       tick;
  logic [19:0]                lim_m1;
  logic [HBP_NPAIR-1:0][11:0] rd_pair;

  assign rd_pair = {2'h0, s_q.tcap, 2'h0, s_q.tcnt, s_q.cnt, s_q.pair};

  always_comb begin
    s_d      = s_q;
    req      = wb_i.cyc && wb_i.stb;
    wr       = req && s_q.ack && wb_i.we && wb_i.sel[0];
    s_d.ack  = req && !s_q.ack;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    if (req && !s_q.ack) begin
      s_d.rdat = 32'h0000_0000;
      if (!wb_i.we) begin
        case (wb_i.adr)
          HBP_OFS_CTRL: s_d.rdat = {23'h0, s_q.mdat, s_q.msel, s_q.turnoff, s_q.abort, s_q.sde, s_q.dead_time_enable, s_q.run};
          HBP_OFS_STAT: s_d.rdat = {23'h0, s_q.flag};
          HBP_OFS_SDEN: s_d.rdat = {28'h0, s_q.sden};
          HBP_OFS_STEP: s_d.rdat = {24'h0, s_q.step};
          HBP_OFS_WIN:  s_d.rdat = {24'h0, s_q.win};
          HBP_OFS_TMC0: s_d.rdat = {25'h0, s_q.tcks, s_q.tcon, s_q.stsel};
          HBP_OFS_TMC1: s_d.rdat = {24'h0, s_q.tmode, 6'h0};
          default: s_d.rdat = 32'h0000_0000;
        endcase
        for (int k = 0; k < HBP_NPAIR; k++) begin
          if (wb_i.adr == 8'(HBP_OFS_PAIR + HBP_PAIR_STRIDE * k))
            s_d.rdat = {24'h0, s_q.lowbuf};
          if (wb_i.adr == 8'(HBP_OFS_PAIR + HBP_PAIR_STRIDE * k + HBP_PAIR_HI)) begin
            s_d.rdat   = {28'h0, rd_pair[k][11:8]};
            s_d.lowbuf = rd_pair[k][7:0];
          end
        end
      end
    end

    if (wr) begin
      case (wb_i.adr)
        HBP_OFS_CTRL: {s_d.mdat, s_d.msel, s_d.turnoff, s_d.abort, s_d.sde, s_d.dead_time_enable, s_d.run} = wb_i.dat[8:0];
        HBP_OFS_STAT: s_d.flag = s_q.flag & ~wb_i.dat[8:0];
        HBP_OFS_SDEN: s_d.sden = wb_i.dat[3:0];
        HBP_OFS_STEP: s_d.step = wb_i.dat[7:0];
        HBP_OFS_WIN:  s_d.win  = wb_i.dat[7:0];
        HBP_OFS_TMC0: {s_d.tcks, s_d.tcon, s_d.stsel} = wb_i.dat[6:0];
        HBP_OFS_TMC1: s_d.tmode = wb_i.dat[7:6];
        default: s_d.tmode = s_q.tmode;
      endcase
      for (int k = 0; k < HBP_NPAIR_W; k++) begin
        // low write fills buffer, high commits
        if (wb_i.adr == 8'(HBP_OFS_PAIR + HBP_PAIR_STRIDE * k))
          s_d.lowbuf = wb_i.dat[7:0];
        if (wb_i.adr == 8'(HBP_OFS_PAIR + HBP_PAIR_STRIDE * k + HBP_PAIR_HI))
          s_d.pair[k] = {wb_i.dat[3:0], s_q.lowbuf};
      end
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    s_d.zs1 = {zero_current_b_i, zero_current_a_i};
    s_d.zs2 = s_q.zs1;
    s_d.os1 = {overvolt_src_e_i, overvolt_src_d_i, overvolt_src_c_i};
    s_d.os2 = s_q.os1;
    s_d.es  = {s_q.es[1:0], event_clock_signal_i};
    s_d.ls  = {s_q.ls[1:0], low_clk_i};

    // ----------------------------------------------------------------
    // PWM counter and reload
    // ----------------------------------------------------------------
    // period is period_reg plus one
    wrap   = s_q.run && (s_q.cnt == s_q.per_act);
    main_w = s_q.run && (s_q.cnt <= s_q.duty_act);
    raw    = {s_q.run && !main_w, main_w};
    if (s_q.run && s_q.cnt == s_q.duty_act)
      s_d.flag[HBP_F_DUTY] = 1'b1;
    if (wrap)
      s_d.flag[HBP_F_PER] = 1'b1;

    stepping = s_q.flag[HBP_F_SD] && s_q.sde && !s_q.step_end;
    diff     = {1'b0, s_q.pair[HBP_P_PER]} - {5'h0, s_q.step};
    if (!s_q.flag[HBP_F_SD]) begin
      // Clearing the shutdown flag cancels any pending stop
      s_d.step_end  = 1'b0;
      s_d.stop_req  = 1'b0;
      s_d.stop_full = 1'b0;
    end else if (stepping && s_q.abort) begin
      // abort without command keeps run state
      // abort with command does full turn-off
      s_d.step_end  = 1'b1;
      s_d.stop_req  = 1'b1;
      s_d.stop_full = s_q.turnoff;
    end else if (stepping && wrap) begin
      if (!diff[12] && diff[11:0] >= s_q.pair[HBP_P_MIN]) begin
        s_d.pair[HBP_P_PER] = diff[11:0];
      end else begin
        s_d.step_end  = 1'b1;
        s_d.stop_req  = s_q.turnoff;
        s_d.stop_full = 1'b1;
      end
    end
    if (s_q.flag[HBP_F_SD] && !s_q.sde && !s_q.turnoff) begin
      s_d.turnoff   = 1'b1;
      s_d.stop_req  = 1'b1;
      s_d.stop_full = 1'b1;
    end

    // buffered values apply at count zero
    if (!s_q.run || wrap) begin
      s_d.cnt      = 12'h000;
      s_d.per_act  = s_d.pair[HBP_P_PER];
      s_d.duty_act = s_d.pair[HBP_P_DUTY];
      s_d.dt_act   = s_d.pair[HBP_P_DTA+1:HBP_P_DTA];
    end else begin
      s_d.cnt = s_q.cnt + 12'h001;
    end

    // end of period: manual outputs; stop only if stop_full
    if (wrap && s_q.stop_req) begin
      s_d.stop_req = 1'b0;
      s_d.msel     = 2'b11;
      if (s_q.stop_full) begin
        s_d.run            = 1'b0;
        s_d.flag[HBP_F_OD] = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Dead time and phase detection per output
    // ----------------------------------------------------------------
    thr = {1'b0, s_q.win} + 9'h001;
    for (int i = 0; i < 2; i++) begin
      // rising edge delayed dead time plus one
      if (s_q.msel[i]) begin
        s_d.pout[i] = s_q.mdat[i];
        s_d.dcnt[i] = 12'h000;
      end else if (!raw[i]) begin
        s_d.pout[i] = 1'b0;
        s_d.dcnt[i] = 12'h000;
      end else if (!s_q.dead_time_enable || s_q.dcnt[i] > s_q.dt_act[i] || s_q.dcnt[i] == 12'hFFF) begin
        s_d.pout[i] = 1'b1;
      end else begin
        s_d.dcnt[i] = s_q.dcnt[i] + 12'h001;
      end
      ph[i] = s_q.pout[i] && !s_q.zs2[i];
      s_d.pprev[i] = s_q.pout[i];
      if (s_q.pout[i] && !s_q.pprev[i])
        s_d.pw[i] = {8'h00, ph[i]};
      else if (ph[i] && s_q.pw[i] != HBP_PW_MAX)
        s_d.pw[i] = s_q.pw[i] + 9'h001;
      ev[i] = s_q.pprev[i] && !s_q.pout[i] && !s_q.msel[i];
      if (ev[i] && s_q.pw[i] == 9'h000)
        s_d.flag[HBP_F_ZP] = 1'b1;
      if (ev[i] && s_q.pw[i] != 9'h000 && s_q.pw[i] < thr)
        s_d.flag[HBP_F_SP] = 1'b1;
      // protect on zero or short width
      if (ev[i] && s_q.pw[i] < thr)
        s_d.flag[HBP_F_PP] = 1'b1;
    end

    if (|(s_q.sden & {s_q.flag[HBP_F_PP], s_q.os2}))
      s_d.flag[HBP_F_SD] = 1'b1;

    // ----------------------------------------------------------------
    // Tick counter
    // ----------------------------------------------------------------
    s_d.presc = s_q.presc + 6'h01;
    case (s_q.tcks)
      3'h0:    tick = (s_q.presc[1:0] == 2'h3);
      3'h1:    tick = 1'b1;
      3'h2:    tick = (s_q.presc[3:0] == 4'hF);
      3'h3:    tick = (s_q.presc == 6'h3F);
      3'h4:    tick = s_q.ls[1] && !s_q.ls[2];
      3'h5:    tick = s_q.ls[1] && !s_q.ls[2];
      3'h6:    tick = s_q.es[1] && !s_q.es[2];
      3'h7:    tick = !s_q.es[1] && s_q.es[2];
      default: tick = 1'b0;
    endcase
    lim_m1 = 20'((21'(SAMPLE_BASE_CYC) << s_q.stsel) - 21'h1);
    if (s_d.tcon && !s_q.tcon) begin
      s_d.tcnt = 10'h000;
      s_d.tcap = 10'h000;
      s_d.samp = 20'h0_0000;
    end else if (s_q.tcon) begin
      if (tick)
        s_d.tcnt = s_q.tcnt + 10'h001;
      if (tick && s_q.tmode[1] && s_q.tcnt == HBP_TICK_MAX - 10'h001)
        s_d.flag[HBP_F_OVF] = 1'b1;
      s_d.samp = s_q.samp + 20'h0_0001;
      // capture and stop when sample elapses
      if (s_q.tmode[1] && s_q.samp == lim_m1) begin
        s_d.tcap            = s_q.tcnt;
        s_d.flag[HBP_F_CAP] = 1'b1;
        s_d.tcon            = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      s_q <= HBP_STATE_RST;
    else
      s_q <= s_d;
  end

  assign wb_ack_o   = s_q.ack;
  assign wb_dat_o   = s_q.rdat;
  assign output_a_o = s_q.pout[0];
  assign output_b_o = s_q.pout[1];
  assign phase_o    = {s_q.pout[1] & ~s_q.zs2[1], s_q.pout[0] & ~s_q.zs2[0]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_stop_at_end;
    wrap && s_q.stop_req && s_q.stop_full;
  endsequence

  chk_period_wrap:
  assert property (wrap |=> s_q.cnt == 12'h000 && s_q.per_act == $past(s_d.per_act))
    else $error("counter did not restart after period");
  chk_output_inverse:
  assert property ($past(!rst_i) && $past(s_q.run && !s_q.dead_time_enable && s_q.msel == 2'b00)
                   |-> output_a_o != output_b_o)
    else $error("outputs not complementary");
  chk_duty_flag:
  assert property (s_q.run && s_q.cnt == s_q.duty_act |=> s_q.flag[HBP_F_DUTY])
    else $error("duty match flag missing");
  chk_reload_zero:
  assert property ($changed(s_q.duty_act) |-> s_q.cnt == 12'h000)
    else $error("duty applied away from zero");
  chk_dead_a:
  assert property ($rose(s_q.pout[0]) && $past(s_q.dead_time_enable && !s_q.msel[0])
                   |-> $past(s_q.dcnt[0]) > $past(s_q.dt_act[0]) || $past(s_q.dcnt[0]) == 12'hFFF)
    else $error("output A rose before dead time");
  chk_dead_b:
  assert property ($rose(s_q.pout[1]) && $past(s_q.dead_time_enable && !s_q.msel[1])
                   |-> $past(s_q.dcnt[1]) > $past(s_q.dt_act[1]) || $past(s_q.dcnt[1]) == 12'hFFF)
    else $error("output B rose before dead time");
  chk_phase_protect:
  assert property (|(ev & {s_q.pw[1] < thr, s_q.pw[0] < thr}) |=> s_q.flag[HBP_F_PP])
    else $error("phase protect flag missing");
  chk_zero_phase:
  assert property (ev[0] && s_q.pw[0] == 9'h000 |=> s_q.flag[HBP_F_ZP] && s_q.flag[HBP_F_PP])
    else $error("zero phase flag missing");
  chk_shutdown_set:
  assert property (s_q.sden[3] && s_q.flag[HBP_F_PP] |=> s_q.flag[HBP_F_SD])
    else $error("shutdown flag missing");
  chk_turnoff_done:
  assert property (s_stop_at_end |=> !s_q.run && s_q.msel == 2'b11 && s_q.flag[HBP_F_OD])
    else $error("turn-off incomplete at period end");
  chk_step_down:
  assert property (stepping && wrap && !s_q.abort && !diff[12] && diff[11:0] >= s_q.pair[HBP_P_MIN]
                   |=> s_q.per_act == $past(diff[11:0]))
    else $error("period not stepped down");
  chk_abort_keep:
  assert property (stepping && s_q.abort && !s_q.turnoff |=> s_q.stop_req && !s_q.stop_full ##1 !stepping)
    else $error("abort did not stop stepping");
  chk_tick_capture:
  assert property (s_q.tcon && s_q.tmode[1] && s_q.samp == lim_m1
                   |=> !s_q.tcon && s_q.flag[HBP_F_CAP] && s_q.tcap == $past(s_q.tcnt))
    else $error("capture at sample end missing");
  chk_tick_clear:
  assert property ($rose(s_q.tcon) |-> s_q.tcnt == 10'h000 && s_q.tcap == 10'h000)
    else $error("counter not cleared on enable");

endmodule // hbp_top

// file: sim/hbp_zc_model.sv
// Zero-current comparator model at the half-bridge far side.
// Assumes the gate drives of hbp_top and the bench clock.
`timescale 1ns/1ps
module hbp_zc_model (
  // Clock, reset, lag control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] lag_i,
  input  wire logic       lead_i,
  // Gate drives in, current signs out
  input  wire logic       output_a_i,
  input  wire logic       output_b_i,
  output logic            zero_current_a_o,
  output logic            zero_current_b_o
);
  logic [15:0] dly_a_q;
  logic [15:0] dly_b_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_a_q <= 16'h0000;
      dly_b_q <= 16'h0000;
    end else begin
      dly_a_q <= {dly_a_q[14:0], output_a_i};
      dly_b_q <= {dly_b_q[14:0], output_b_i};
    end
  end

  assign zero_current_a_o = lead_i | dly_a_q[lag_i];
  assign zero_current_b_o = lead_i | dly_b_q[lag_i];
endmodule // hbp_zc_model

// file: sim/halfbridge_pwm_phase_protect_tb_top.sv
// Self-checking bench for hbp_top: registers, PWM, protection, tick counter.
// Assumes hbp_zc_model on the far side and a 250 MHz clock.
`timescale 1ns/1ps
module halfbridge_pwm_phase_protect_tb_top;
  import hbp_pkg::*;
  // Not a power of two, so captures do not wrap to zero
  localparam int SB = 20;
  logic        clk_i, rst_i, wb_ack_o, zc_a, zc_b, ovc, ovd, ove, evt, lowc, out_a, out_b, lead;
  hbp_wb_req_t wb_i;
  logic [31:0] wb_dat_o, rv;
  logic [1:0]  phase;
  logic [3:0]  lag;
  int          fails, total_checks, per, duty, n, hi, pd;

  hbp_top #(.SAMPLE_BASE_CYC(SB)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .zero_current_a_i(zc_a), .zero_current_b_i(zc_b), .overvolt_src_c_i(ovc),
    .overvolt_src_d_i(ovd), .overvolt_src_e_i(ove), .event_clock_signal_i(evt), .low_clk_i(lowc),
    .output_a_o(out_a), .output_b_o(out_b), .phase_o(phase));
  hbp_zc_model zc (.clk_i(clk_i), .rst_i(rst_i), .lag_i(lag), .lead_i(lead), .output_a_i(out_a),
    .output_b_i(out_b), .zero_current_a_o(zc_a), .zero_current_b_o(zc_b));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Bus, measurement and expectation helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && t < 20) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 20) fails++;
    q = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  // Low byte only fills the buffer; high byte commits
  task automatic wr_pair(input int k, input logic [11:0] v);
    wr(HBP_OFS_PAIR + 8'(k) * HBP_PAIR_STRIDE, {24'h0, v[7:0]});
    wr(HBP_OFS_PAIR + 8'(k) * HBP_PAIR_STRIDE + HBP_PAIR_HI, {28'h0, v[11:8]});
  endtask

  task automatic rd_pair(input int k, output logic [31:0] v);
    logic [31:0] h, l;
    rd(HBP_OFS_PAIR + 8'(k) * HBP_PAIR_STRIDE + HBP_PAIR_HI, h);
    rd(HBP_OFS_PAIR + 8'(k) * HBP_PAIR_STRIDE, l);
    v = {h[23:0], l[7:0]};
  endtask

  task automatic span(input int s, input logic lvl, output int c);
    c = 0;
    while ((s ? out_b : out_a) === lvl && c < 9000) begin
      @(posedge clk_i);
      c++;
    end
  endtask

  task automatic measure(input int s, output int h, output int p);
    int x;
    span(s, 1'b1, x);
    span(s, 1'b0, x);
    span(s, 1'b1, h);
    span(s, 1'b0, p);
    p += h;
  endtask

  function automatic int exp_hi(input int s, input int dead_time_enable, input int dt);
    int raw;
    raw = s ? per - duty : duty + 1;
    return dead_time_enable ? raw - dt - 1 : raw;
  endfunction

  function automatic int stepped(input int p, input int s, input int m);
    while (p - s >= m) p -= s;
    return p;
  endfunction

  function automatic logic [31:0] near(input logic [9:0] got, input int exp);
    logic [9:0] d;
    d = got - 10'(exp);
    return {31'h0, d < 10'h008 || d > 10'h3F8};
  endfunction

  task automatic conclude();
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Sequence needs about 15000 cycles
  initial begin
    #(4 * 60000);
    fails++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int dt[2];
    fails = 0;
    total_checks = 0;
    rst_i = 1'b1;
    wb_i = '0;
    {ovc, ovd, ove, evt, lowc, lead} = 6'h00;
    lag = 4'h5;
    void'($urandom(65741));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, read-only pairs, unmapped space, window register
    for (int k = 6; k < 8; k++) begin
      wr_pair(k, 12'hFFF);
      rd_pair(k, rv);
      chk(rv, 32'h0);
    end
    rd(HBP_OFS_WIN, rv);
    chk(rv, 32'h0);
    rd(8'hFC, rv);
    chk(rv, 32'h0);
    n = $urandom_range(255);
    wr(HBP_OFS_WIN, 32'(n));
    rd(HBP_OFS_WIN, rv);
    chk(rv, 32'(n));
    // Period, duty, complement, dead time on both legs
    for (int dead_time_enable = 0; dead_time_enable < 2; dead_time_enable++) begin
      per = $urandom_range(40, 20);
      duty = $urandom_range(per - 8, 8);
      dt[0] = $urandom_range(3);
      dt[1] = $urandom_range(3);
      wr_pair(HBP_P_PER, 12'(per));
      wr_pair(HBP_P_DUTY, 12'(duty));
      wr_pair(HBP_P_DTA, 12'(dt[0]));
      wr_pair(HBP_P_DTA + 1, 12'(dt[1]));
      wr(HBP_OFS_CTRL, 32'(1 + 2 * dead_time_enable));
      for (int s = 0; s < 2; s++) begin
        measure(s, hi, pd);
        chk(32'(hi), 32'(exp_hi(s, dead_time_enable, dt[s])));
        chk(32'(pd), 32'(per + 1));
      end
      if (dead_time_enable == 0) repeat (30) begin
        @(posedge clk_i);
        chk({31'h0, out_b}, {31'h0, ~out_a});
      end
      rd(HBP_OFS_STAT, rv);
      chk(rv & 32'h3, 32'h3);
      wr(HBP_OFS_CTRL, 32'h0);
      wr(HBP_OFS_STAT, 32'h1FF);
      rd(HBP_OFS_STAT, rv);
      chk(rv & 32'h3, 32'h0);
    end
    // Zero, short and wide phase; protect turns the bridge off
    per = 600;
    duty = 300;
    wr_pair(HBP_P_PER, 12'(per));
    wr_pair(HBP_P_DUTY, 12'(duty));
    for (int c = 0; c < 3; c++) begin
      lead <= (c == 0);
      lag <= (c == 1) ? 4'h5 : 4'hA;
      wr(HBP_OFS_WIN, c == 2 ? 32'h0 : 32'hC8);
      wr(HBP_OFS_SDEN, 32'h8);
      wr(HBP_OFS_CTRL, 32'h81);
      repeat (2000) @(posedge clk_i);
      rd(HBP_OFS_STAT, rv);
      chk(rv & 32'h7C, c == 0 ? 32'h74 : c == 1 ? 32'h6C : 32'h0);
      rd(HBP_OFS_CTRL, rv);
      chk(rv & 32'hE1, c == 2 ? 32'h81 : 32'hE0);
      if (c < 2) chk({30'h0, out_b, out_a}, 32'h1);
      wr(HBP_OFS_SDEN, 32'h0);
      wr(HBP_OFS_CTRL, 32'h0);
      wr(HBP_OFS_STAT, 32'h1FF);
    end
    // Source gating, period step-down, finish or abort
    for (int i = 0; i < 3; i++) begin
      per = $urandom_range(60, 30);
      n = $urandom_range(9, 3);
      pd = $urandom_range(20, 10);
      wr_pair(HBP_P_PER, 12'(per));
      wr_pair(HBP_P_DUTY, 12'h008);
      wr_pair(HBP_P_MIN, 12'(pd));
      wr(HBP_OFS_STEP, 32'(n));
      wr(HBP_OFS_SDEN, 32'(1 << i));
      wr(HBP_OFS_CTRL, i == 2 ? 32'hD : 32'h15);
      {ovc, ovd, ove} <= 3'(4 >> ((i + 1) % 3));
      repeat (50) @(posedge clk_i);
      rd(HBP_OFS_STAT, rv);
      chk(rv & 32'h20, 32'h0);
      {ovc, ovd, ove} <= 3'(4 >> i);
      repeat (1500) @(posedge clk_i);
      rd_pair(HBP_P_PER, rv);
      chk(rv, 32'(i == 2 ? per : stepped(per, n, pd)));
      rd(HBP_OFS_CTRL, rv);
      chk(rv & 32'h61, i == 2 ? 32'h61 : 32'h60);
      rd(HBP_OFS_STAT, rv);
      chk(rv & 32'h60, i == 2 ? 32'h20 : 32'h60);
      {ovc, ovd, ove} <= 3'h0;
      wr(HBP_OFS_SDEN, 32'h0);
      wr(HBP_OFS_CTRL, 32'h0);
      wr(HBP_OFS_STAT, 32'h1FF);
    end
    // Timed capture, overflow past the top and wrap
    wr(HBP_OFS_TMC1, 32'h80);
    for (int j = 0; j < 3; j++) begin
      n = (j == 2) ? 7 : $urandom_range(3);
      wr(HBP_OFS_TMC0, 32'h18 | 32'(n));
      repeat ((SB << n) + 40) @(posedge clk_i);
      rd(HBP_OFS_TMC0, rv);
      chk(rv & 32'h8, 32'h0);
      rd_pair(7, rv);
      chk(near(rv[9:0], SB << n), 32'h1);
      rd(HBP_OFS_STAT, rv);
      chk(rv & 32'h180, j == 2 ? 32'h180 : 32'h100);
      wr(HBP_OFS_STAT, 32'h1FF);
    end
    rd_pair(6, rv);
    chk(near(rv[9:0], SB << 7), 32'h1);
    // Low-speed and event clocks; counter_on rise clears capture
    for (int j = 0; j < 2; j++) begin
      n = $urandom_range(20, 1);
      wr(HBP_OFS_TMC0, 32'h0);
      wr(HBP_OFS_TMC0, j ? 32'h6F : 32'h4F);
      rd_pair(7, rv);
      chk(rv, 32'h0);
      repeat (n) begin
        {evt, lowc} <= j ? 2'b10 : 2'b01;
        repeat (4) @(posedge clk_i);
        {evt, lowc} <= 2'b00;
        repeat (4) @(posedge clk_i);
      end
      repeat (8) @(posedge clk_i);
      rd_pair(6, rv);
      chk(rv, 32'(n));
    end
    conclude();
  end
endmodule // halfbridge_pwm_phase_protect_tb_top
